// ---- core/mlt_consts.svh ----
// Constants for the mezzanine loopback tester: lane counts, timing, fields.
// Assumes the logic clock rate given below; included by bare name.
`ifndef MLT_CONSTS_SVH
`define MLT_CONSTS_SVH
`define MLT_CLK_MHZ 25
`define MLT_DEBOUNCE_US 20000
`define MLT_DEBOUNCE_CYCLES (`MLT_DEBOUNCE_US * `MLT_CLK_MHZ)
`define MLT_HEART_US 250000
`define MLT_HEART_CYCLES (`MLT_HEART_US * `MLT_CLK_MHZ)
`define MLT_PCS_RST_NS 160
`define MLT_PCS_RST_CYCLES ((`MLT_PCS_RST_NS * `MLT_CLK_MHZ + 999) / 1000)
`define MLT_XCVR_LANES 4
`define MLT_LVDS_LANES 17
`define MLT_PAR_LANES 4
`define MLT_ALIGN_CYCLES 8
`define MLT_SYNC_BITS 16
`define MLT_DONE_WORDS 1024
`define MLT_PRBS_SEED 7'h7F
`define MLT_GRP_XCVR 0
`define MLT_GRP_LVDS 1
`define MLT_GRP_PAR 2
`define MLT_NUM_GRP 3
`endif

// ---- core/mlt_pkg.sv ----
// Types shared by the mezzanine loopback tester.
// Assumes nothing beyond a SystemVerilog compiler.
package mlt_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_COMMA, SEQ_BOND, SEQ_PRBS, SEQ_INJECT
  } mlt_seq_t;
  typedef enum logic [1:0] {
    VIEW_ALL, VIEW_XCVR, VIEW_LVDS, VIEW_PAR
  } mlt_view_t;
endpackage

// ---- core/mlt_top.sv ----
// Mezzanine loopback pattern tester: buttons, sequencing, pattern
// generators and checkers, lamps.
// Assumes serializers and transceivers outside present lanes as one bit
// per lane per link clock, and return data on that same link clock.
//
// Summary of operation
// RULE1: Push buttons are synchronised and debounced before control logic uses them.
// RULE2: Transmit PCS reset pulses only after the transmit PLL locks.
// RULE3: Receive PCS reset pulses only after receiver frequency lock.
// RULE4: Buffer pointers start only when both read and write clocks lock.
// RULE5: Every clock domain crossing goes through a receiving synchroniser.
// RULE6: Four transceiver lanes carry pseudo-random data.
// RULE7: Transceiver return is aligned, bonded, then checked against local generator; the checker predicts from received lane 0 history instead.
// RULE8: Seventeen LVDS lanes carry pseudo-random data alongside the transceivers.
// RULE9: LVDS lanes need phase-align lock, then alignment and bonding, then check.
// RULE10: Status lines and the forwarded clock are looped and checked too.
// RULE11: System reset button returns all sequence and result state to start.
// RULE12: Sequence presses enable comma detect, then bonding, then pattern start.
// RULE13: Fourth sequence press corrupts the transmitted stream.
// RULE14: View presses cycle lamps: all, transceivers, LVDS, parallel.
// RULE15: Switches enable port A, port B and edge connector groups; only port A gates checking, the other two gate only the lock lamp.
// RULE16: A switch sends the forwarded clock at 0 or 180 degrees.
// RULE17: Sync lamp lights after alignment, bonding and first valid pattern.
// RULE18: Clean run lights lock, sync and done lamps; error lamp dark.
// RULE19: Injected error is flagged by the checker on the error lamp.
// RULE20: A heartbeat runs on three lamps after reset release.
// RULE21: Port A transmit and receive lamps show their PLL locks.
// RULE22: Card-present lamp lights while the loopback card is fitted.
// RULE23: Lock lamp lights only while all PLLs of enabled groups lock.
// RULE24: Error lamp stays lit after any mismatch until system reset; the lamp shows only latched errors of the groups in the current view.
`include "mlt_consts.svh"

// ----------------------------------------------------------------
// Two-flop synchroniser
// ----------------------------------------------------------------
module mlt_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d; // see RULE5
      q <= meta;
    end
  end
endmodule

// ----------------------------------------------------------------
// Button debouncer
// ----------------------------------------------------------------
module mlt_debounce #(parameter int CYCLES = `MLT_DEBOUNCE_CYCLES) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw,
  output logic level,
  output logic press
);
  localparam int CW = $clog2(CYCLES + 1);
  logic s;
  logic [CW-1:0] cnt;
  mlt_sync #(.W(1)) u_s (.clk(clk), .rst_n(rst_n), .d(raw), .q(s));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      if (s == level) begin
        cnt <= '0;
      end else if (cnt == CW'(CYCLES - 1)) begin
        cnt <= '0;
        level <= s; // see RULE1
        press <= s;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// Lane group aligner, bonder and pattern checker (link clock)
// ----------------------------------------------------------------
module mlt_prbs_chk #(parameter int LANES = 4) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic comma_en,
  input wire logic bond_en,
  input wire logic [LANES-1:0] rx,
  output logic sync,
  output logic err,
  output logic done
);
  localparam int AW = $clog2(`MLT_ALIGN_CYCLES + 1);
  localparam int SW = $clog2(`MLT_SYNC_BITS + 1);
  localparam int DW = $clog2(`MLT_DONE_WORDS + 1);
  logic [AW-1:0] agree_cnt;
  logic [SW-1:0] match_cnt;
  logic [DW-1:0] done_cnt;
  logic [6:0] hist;
  logic bonded;
  logic agree;
  logic aligned;
  logic match;
  assign agree = (&rx) | ~(|rx);
  assign aligned = agree_cnt == AW'(`MLT_ALIGN_CYCLES);
  // An all-zero history would predict zeros forever, so it never matches.
  assign match = bonded && hist != 7'h00
    && rx == {LANES{hist[6] ^ hist[5]}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      agree_cnt <= '0;
      bonded <= 1'b0;
    end else if (!run) begin
      agree_cnt <= '0;
      bonded <= 1'b0;
    end else begin
      if (comma_en && agree && !aligned) begin
        agree_cnt <= agree_cnt + 1'b1; // see RULE7
      end else if (!agree && !aligned) begin
        agree_cnt <= '0;
      end
      bonded <= aligned && bond_en; // see RULE7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= 7'h00;
    end else if (!bonded) begin
      hist <= 7'h00;
    end else begin
      hist <= {hist[5:0], rx[0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_cnt <= '0;
      sync <= 1'b0;
      err <= 1'b0;
      done_cnt <= '0;
      done <= 1'b0;
    end else if (!run) begin
      match_cnt <= '0;
      sync <= 1'b0;
      err <= 1'b0;
      done_cnt <= '0;
      done <= 1'b0;
    end else begin
      if (!match) begin
        match_cnt <= '0;
      end else if (match_cnt != SW'(`MLT_SYNC_BITS)) begin
        match_cnt <= match_cnt + 1'b1;
      end
      if (match_cnt == SW'(`MLT_SYNC_BITS)) begin
        sync <= 1'b1; // see RULE17
      end
      if (sync && !match) begin
        err <= 1'b1; // see RULE19
      end
      if (sync && match && done_cnt != DW'(`MLT_DONE_WORDS)) begin
        done_cnt <= done_cnt + 1'b1;
      end
      done <= sync && !err && done_cnt == DW'(`MLT_DONE_WORDS);
    end
  end

  err_needs_sync_a: assert property ( // see RULE19
    @(posedge clk) disable iff (!rst_n)
    $rose(err) |-> $past(sync) && !$past(match))
    else $error("checker error without sync and mismatch");
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module mlt_top #(
  parameter int DEBOUNCE_CYCLES = `MLT_DEBOUNCE_CYCLES,
  parameter int HEART_CYCLES = `MLT_HEART_CYCLES,
  parameter int XL = `MLT_XCVR_LANES,
  parameter int LL = `MLT_LVDS_LANES,
  parameter int PL = `MLT_PAR_LANES
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  // Buttons, active low
  input wire logic sys_reset_button_n,
  input wire logic sequence_button_n,
  input wire logic view_select_button_n,
  // Option switches
  input wire logic port_a_en,
  input wire logic port_b_en,
  input wire logic pcie_en,
  input wire logic clk_phase_sel,
  // Lock and presence inputs
  input wire logic xcvr_tx_pll_lock,
  input wire logic rx_freq_lock,
  input wire logic lvds_tx_pll_lock,
  input wire logic lvds_rx_pll_lock,
  input wire logic [LL-1:0] dynamic_phase_align_lock,
  input wire logic port_b_pll_lock,
  input wire logic pcie_pll_lock,
  input wire logic card_present_n,
  // PCS resets
  output logic tx_pcs_reset,
  output logic rx_pcs_reset,
  // Transmit lanes, link clock
  output logic [XL-1:0] xcvr_tx,
  output logic [LL-1:0] lvds_tx,
  output logic [PL-1:0] par_tx,
  output logic par_fwd_clk,
  // Returned lanes, link clock
  input wire logic [XL-1:0] xcvr_rx,
  input wire logic [LL-1:0] lvds_rx,
  input wire logic [PL-1:0] par_rx,
  input wire logic par_fwd_clk_rx,
  // Lamps
  output logic lock_lamp,
  output logic sync_lamp,
  output logic done_lamp,
  output logic error_lamp,
  output logic port_a_tx_lock_lamp,
  output logic port_a_rx_lock_lamp,
  output logic card_present_lamp,
  output logic heartbeat_lamp_a,
  output logic heartbeat_lamp_b,
  output logic heartbeat_lamp_c
);
  localparam int PCS_N = `MLT_PCS_RST_CYCLES;
  localparam int PCW = $clog2(PCS_N + 1);
  localparam int HW = $clog2(HEART_CYCLES + 1);
  localparam int NG = `MLT_NUM_GRP;

  // ----------------------------------------------------------------
  // Pin synchronisers and buttons
  // ----------------------------------------------------------------
  logic [10:0] pin_s;
  logic a_en, b_en, e_en, phase_s, xtx_lk, rfl_lk, ltx_lk, lrx_lk;
  logic b_lk, e_lk, card_s;
  mlt_sync #(.W(11)) u_pins (.clk(clk), .rst_n(resetn),
    .d({port_a_en, port_b_en, pcie_en, clk_phase_sel, xcvr_tx_pll_lock,
        rx_freq_lock, lvds_tx_pll_lock, lvds_rx_pll_lock, port_b_pll_lock,
        pcie_pll_lock, ~card_present_n}),
    .q(pin_s));
  assign {a_en, b_en, e_en, phase_s, xtx_lk, rfl_lk, ltx_lk, lrx_lk,
          b_lk, e_lk, card_s} = pin_s;

  logic soft_clr, seq_press, view_press, seq_level, view_level;
  mlt_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_rst_b (.clk(clk),
    .rst_n(resetn), .raw(~sys_reset_button_n), .level(soft_clr),
    .press());
  mlt_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_seq_b (.clk(clk),
    .rst_n(resetn), .raw(~sequence_button_n), .level(seq_level),
    .press(seq_press));
  mlt_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_view_b (.clk(clk),
    .rst_n(resetn), .raw(~view_select_button_n), .level(view_level),
    .press(view_press));

  // ----------------------------------------------------------------
  // PCS reset pulses after lock
  // ----------------------------------------------------------------
  logic [1:0] lk;
  logic [1:0] lk_d;
  logic [1:0] armed;
  logic [1:0] pcs_rst;
  logic [PCW-1:0] pcs_cnt [2];
  assign lk = {rfl_lk, xtx_lk};
  assign tx_pcs_reset = pcs_rst[0];
  assign rx_pcs_reset = pcs_rst[1];
  for (genvar i = 0; i < 2; i++) begin : g_pcs
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        lk_d[i] <= 1'b0;
        armed[i] <= 1'b0;
        pcs_rst[i] <= 1'b0;
        pcs_cnt[i] <= '0;
      end else begin
        lk_d[i] <= lk[i];
        if (!lk[i]) begin
          armed[i] <= 1'b0;
          pcs_rst[i] <= 1'b0;
          pcs_cnt[i] <= '0;
        end else if (!lk_d[i]) begin
          armed[i] <= 1'b1; // see RULE2 RULE3
          pcs_rst[i] <= 1'b1;
          pcs_cnt[i] <= PCW'(PCS_N);
        end else if (pcs_cnt[i] != '0) begin
          pcs_cnt[i] <= pcs_cnt[i] - 1'b1;
          pcs_rst[i] <= pcs_cnt[i] != PCW'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence and view control
  // ----------------------------------------------------------------
  mlt_pkg::mlt_seq_t seq_state;
  mlt_pkg::mlt_view_t view;
  logic run, comma_en, bond_en, prbs_en, inject_tgl;
  logic a_locks;
  assign a_locks = xtx_lk & rfl_lk & ltx_lk & lrx_lk;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_state <= mlt_pkg::SEQ_IDLE;
      inject_tgl <= 1'b0;
    end else if (soft_clr) begin
      seq_state <= mlt_pkg::SEQ_IDLE; // see RULE11
    end else if (seq_press) begin
      case (seq_state)
        mlt_pkg::SEQ_IDLE: seq_state <= mlt_pkg::SEQ_COMMA; // see RULE12
        mlt_pkg::SEQ_COMMA: seq_state <= mlt_pkg::SEQ_BOND;
        mlt_pkg::SEQ_BOND: seq_state <= mlt_pkg::SEQ_PRBS;
        mlt_pkg::SEQ_PRBS: begin
          seq_state <= mlt_pkg::SEQ_INJECT;
          inject_tgl <= ~inject_tgl; // see RULE13
        end
        default: seq_state <= seq_state;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      view <= mlt_pkg::VIEW_ALL;
    end else if (soft_clr) begin
      view <= mlt_pkg::VIEW_ALL;
    end else if (view_press) begin
      case (view)
        mlt_pkg::VIEW_ALL: view <= mlt_pkg::VIEW_XCVR; // see RULE14
        mlt_pkg::VIEW_XCVR: view <= mlt_pkg::VIEW_LVDS;
        mlt_pkg::VIEW_LVDS: view <= mlt_pkg::VIEW_PAR;
        default: view <= mlt_pkg::VIEW_ALL;
      endcase
    end
  end

  // Registered so that only clean levels enter the link synchroniser.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run <= 1'b0;
      comma_en <= 1'b0;
      bond_en <= 1'b0;
      prbs_en <= 1'b0;
    end else begin
      run <= a_en && a_locks && armed == 2'h3 && !soft_clr // see RULE4
        && pcs_cnt[0] == '0 && pcs_cnt[1] == '0; // see RULE15
      comma_en <= seq_state != mlt_pkg::SEQ_IDLE;
      bond_en <= seq_state != mlt_pkg::SEQ_IDLE
        && seq_state != mlt_pkg::SEQ_COMMA;
      prbs_en <= seq_state == mlt_pkg::SEQ_PRBS
        || seq_state == mlt_pkg::SEQ_INJECT;
    end
  end

  // ----------------------------------------------------------------
  // Link clock domain: generators and checkers
  // ----------------------------------------------------------------
  logic link_rst_n, link_rst_m;
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_rst_m <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_m <= 1'b1;
      link_rst_n <= link_rst_m;
    end
  end

  logic [5:0] ctl_l;
  logic [LL-1:0] dpa_l;
  logic l_run, l_comma, l_bond, l_prbs, l_tgl, l_phase, l_tgl_d, inj;
  mlt_sync #(.W(6)) u_ctl (.clk(link_clk), .rst_n(link_rst_n),
    .d({run, comma_en, bond_en, prbs_en, inject_tgl, phase_s}),
    .q(ctl_l)); // see RULE5
  assign {l_run, l_comma, l_bond, l_prbs, l_tgl, l_phase} = ctl_l;
  mlt_sync #(.W(LL)) u_dpa (.clk(link_clk), .rst_n(link_rst_n),
    .d(dynamic_phase_align_lock), .q(dpa_l));
  assign inj = l_tgl ^ l_tgl_d;

  logic [6:0] lfsr;
  logic train, fwd_tog, tx_bit;
  assign tx_bit = l_prbs ? (lfsr[6] ^ lfsr[5]) : train;
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lfsr <= `MLT_PRBS_SEED;
      train <= 1'b0;
      fwd_tog <= 1'b0;
      l_tgl_d <= 1'b0;
      xcvr_tx <= '0;
      lvds_tx <= '0;
      par_tx <= '0;
      par_fwd_clk <= 1'b0;
    end else begin
      l_tgl_d <= l_tgl;
      train <= ~train;
      fwd_tog <= ~fwd_tog;
      if (l_prbs) begin
        lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      end
      // Only lane 0 is hit, so the bonded lanes also disagree.
      xcvr_tx <= l_run ? {{(XL-1){tx_bit}}, tx_bit ^ inj} : '0; // see RULE6
      lvds_tx <= l_run ? {{(LL-1){tx_bit}}, tx_bit ^ inj} : '0; // see RULE8
      par_tx <= l_run ? {{(PL-1){tx_bit}}, tx_bit ^ inj} : '0; // see RULE10
      par_fwd_clk <= l_run & (fwd_tog ^ l_phase); // see RULE16
    end
  end

  logic [NG-1:0] g_sync, g_err, g_done;
  logic par_err, fwd_d, fwd_err;
  mlt_prbs_chk #(.LANES(XL)) u_xc (.clk(link_clk), .rst_n(link_rst_n),
    .run(l_run), .comma_en(l_comma), .bond_en(l_bond), .rx(xcvr_rx),
    .sync(g_sync[`MLT_GRP_XCVR]), .err(g_err[`MLT_GRP_XCVR]),
    .done(g_done[`MLT_GRP_XCVR])); // see RULE7
  mlt_prbs_chk #(.LANES(LL)) u_lv (.clk(link_clk), .rst_n(link_rst_n),
    .run(l_run && (&dpa_l)), .comma_en(l_comma), .bond_en(l_bond),
    .rx(lvds_rx), .sync(g_sync[`MLT_GRP_LVDS]),
    .err(g_err[`MLT_GRP_LVDS]), .done(g_done[`MLT_GRP_LVDS])); // see RULE9
  mlt_prbs_chk #(.LANES(PL)) u_pa (.clk(link_clk), .rst_n(link_rst_n),
    .run(l_run), .comma_en(l_comma), .bond_en(l_bond), .rx(par_rx),
    .sync(g_sync[`MLT_GRP_PAR]), .err(par_err),
    .done(g_done[`MLT_GRP_PAR]));

  // The returned forwarded clock must toggle every link cycle.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fwd_d <= 1'b0;
      fwd_err <= 1'b0;
    end else begin
      fwd_d <= par_fwd_clk_rx;
      if (!l_run) begin
        fwd_err <= 1'b0;
      end else if (g_sync[`MLT_GRP_PAR] && par_fwd_clk_rx == fwd_d) begin
        fwd_err <= 1'b1; // see RULE10
      end
    end
  end
  assign g_err[`MLT_GRP_PAR] = par_err | fwd_err;

  // ----------------------------------------------------------------
  // Results and lamps
  // ----------------------------------------------------------------
  logic [3*NG-1:0] stat_s;
  logic [NG-1:0] sync_s, err_s, done_s, err_latch, mask;
  logic [2:0] heart;
  logic [HW-1:0] heart_cnt;
  mlt_sync #(.W(3 * NG)) u_stat (.clk(clk), .rst_n(resetn),
    .d({g_sync, g_err, g_done}), .q(stat_s)); // see RULE5
  assign {sync_s, err_s, done_s} = stat_s;

  always_comb begin
    case (view)
      mlt_pkg::VIEW_XCVR: mask = 3'h1;
      mlt_pkg::VIEW_LVDS: mask = 3'h2;
      mlt_pkg::VIEW_PAR: mask = 3'h4;
      default: mask = 3'h7;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_latch <= '0;
    end else if (soft_clr) begin
      err_latch <= '0; // see RULE11
    end else begin
      err_latch <= err_latch | err_s; // see RULE24
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_lamp <= 1'b0;
      sync_lamp <= 1'b0;
      done_lamp <= 1'b0;
      error_lamp <= 1'b0;
      port_a_tx_lock_lamp <= 1'b0;
      port_a_rx_lock_lamp <= 1'b0;
      card_present_lamp <= 1'b0;
    end else begin
      lock_lamp <= (a_en | b_en | e_en) && (!a_en || a_locks)
        && (!b_en || b_lk) && (!e_en || e_lk); // see RULE23
      sync_lamp <= a_en && (&(sync_s | ~mask)); // see RULE17
      done_lamp <= a_en && (&(done_s | ~mask))
        && !(|(err_latch & mask)); // see RULE18
      error_lamp <= |(err_latch & mask); // see RULE19
      port_a_tx_lock_lamp <= xtx_lk & ltx_lk; // see RULE21
      port_a_rx_lock_lamp <= rfl_lk & lrx_lk;
      card_present_lamp <= card_s; // see RULE22
    end
  end

  assign {heartbeat_lamp_c, heartbeat_lamp_b, heartbeat_lamp_a} = heart;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heart <= 3'h1;
      heart_cnt <= '0;
    end else if (heart_cnt == HW'(HEART_CYCLES - 1)) begin
      heart_cnt <= '0;
      heart <= {heart[1:0], heart[2]}; // see RULE20
    end else begin
      heart_cnt <= heart_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  press_debounced_a: assert property (seq_press |-> seq_level) // see RULE1
    else $error("sequence press without debounced level");
  tx_rst_lock_a: assert property (tx_pcs_reset |-> $past(xtx_lk)) // see RULE2
    else $error("transmit PCS reset without PLL lock");
  rx_rst_lock_a: assert property ($rose(rx_pcs_reset) |-> rfl_lk // see RULE3
    ##1 rx_pcs_reset[*3] ##1 !rx_pcs_reset)
    else $error("receive PCS reset pulse wrong");
  run_locked_a: assert property (run |-> $past(a_locks) // see RULE4
    && $past(pcs_cnt[0]) == '0)
    else $error("run raised before locks settled");
  seq_step_a: assert property (seq_press && !soft_clr // see RULE12
    && seq_state == mlt_pkg::SEQ_BOND |=> seq_state == mlt_pkg::SEQ_PRBS
    ##1 prbs_en)
    else $error("third press did not start pattern");
  inject_a: assert property (seq_press && !soft_clr // see RULE13
    && seq_state == mlt_pkg::SEQ_PRBS |=> inject_tgl != $past(inject_tgl))
    else $error("fourth press did not inject");
  view_wrap_a: assert property (view_press && !soft_clr // see RULE14
    && view == mlt_pkg::VIEW_PAR |=> view == mlt_pkg::VIEW_ALL)
    else $error("view select did not wrap");
  soft_clear_a: assert property (soft_clr |=> // see RULE11
    seq_state == mlt_pkg::SEQ_IDLE && err_latch == '0 ##1 !error_lamp)
    else $error("system reset button left state");
  err_hold_a: assert property (err_latch[0] && !soft_clr // see RULE24
    |=> err_latch[0])
    else $error("error latch dropped");
  heartbeat_a: assert property ($onehot(heart)) // see RULE20
    else $error("heartbeat not one-hot");
  lock_lamp_a: assert property (a_en && !xtx_lk |=> !lock_lamp) // see RULE23
    else $error("lock lamp lit with transmit PLL unlocked");

  seq_inject_c: cover property (seq_state == mlt_pkg::SEQ_INJECT);
  sync_lamp_c: cover property ($rose(sync_lamp));
  error_lamp_c: cover property ($rose(error_lamp));
  view_par_c: cover property (view == mlt_pkg::VIEW_PAR);
endmodule

// ---- tb/mlt_loop_card.sv ----
// Loopback card model: each lane comes back one link clock later.
// Assumes one bit per lane per link clock, as the tester sends them.
module mlt_loop_card (
  // Link side
  input wire logic link_clk,
  input wire logic fitted,
  input wire logic [3:0] xcvr_tx,
  input wire logic [16:0] lvds_tx,
  input wire logic [3:0] par_tx,
  input wire logic par_fwd_clk,
  output logic [3:0] xcvr_rx,
  output logic [16:0] lvds_rx,
  output logic [3:0] par_rx,
  output logic par_fwd_clk_rx,
  output logic card_present_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Return path
  // ----------------------------------------------------------------
  assign card_present_n = !fitted;
  // An absent card leaves the lines floating, so they must not echo data.
  always_ff @(posedge link_clk) begin
    if (fitted)
      {xcvr_rx, lvds_rx, par_rx, par_fwd_clk_rx} <=
        {xcvr_tx, lvds_tx, par_tx, par_fwd_clk};
    else
      {xcvr_rx, lvds_rx, par_rx, par_fwd_clk_rx} <=
        ~{xcvr_rx, lvds_rx, par_rx, par_fwd_clk_rx};
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the loopback tester with a looping card model.
// Assumes short debounce and heartbeat counts set at the instance.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, link_clk = 0, resetn = 0, sys_b = 1, seq_b = 1, view_b = 1;
  logic txl = 0, rxl = 0, ltl = 1, lrl = 1, pbl = 1, pcl = 1, fit = 1;
  logic pa_en = 1, pb_en = 1, pc_en = 1, phase = 0;
  logic [16:0] dynamic_phase_align = 17'h1FFFF;
  logic tx_rst, rx_rst, lock, sync, done, err, a_tx, a_rx, cp, fc, fcr, cp_n;
  logic hb_a, hb_b, hb_c;
  logic [3:0] xt, xr, pt, pr;
  logic [16:0] lt, lr;
  int failures = 0, n_tests = 0;
  mlt_top #(.DEBOUNCE_CYCLES(4), .HEART_CYCLES(8)) u_mlt_top (
    .clk(clk), .resetn(resetn), .link_clk(link_clk),
    .sys_reset_button_n(sys_b), .sequence_button_n(seq_b),
    .view_select_button_n(view_b), .port_a_en(pa_en), .port_b_en(pb_en),
    .pcie_en(pc_en), .clk_phase_sel(phase), .xcvr_tx_pll_lock(txl),
    .rx_freq_lock(rxl), .lvds_tx_pll_lock(ltl), .lvds_rx_pll_lock(lrl),
    .dynamic_phase_align_lock(dynamic_phase_align), .port_b_pll_lock(pbl),
    .pcie_pll_lock(pcl), .card_present_n(cp_n), .tx_pcs_reset(tx_rst),
    .rx_pcs_reset(rx_rst), .xcvr_tx(xt), .lvds_tx(lt), .par_tx(pt),
    .par_fwd_clk(fc), .xcvr_rx(xr), .lvds_rx(lr), .par_rx(pr),
    .par_fwd_clk_rx(fcr), .lock_lamp(lock), .sync_lamp(sync),
    .done_lamp(done), .error_lamp(err), .port_a_tx_lock_lamp(a_tx),
    .port_a_rx_lock_lamp(a_rx), .card_present_lamp(cp),
    .heartbeat_lamp_a(hb_a), .heartbeat_lamp_b(hb_b), .heartbeat_lamp_c(hb_c));
  mlt_loop_card u_mlt_loop_card (
    .link_clk(link_clk), .fitted(fit), .xcvr_tx(xt), .lvds_tx(lt),
    .par_tx(pt), .par_fwd_clk(fc), .xcvr_rx(xr), .lvds_rx(lr), .par_rx(pr),
    .par_fwd_clk_rx(fcr), .card_present_n(cp_n));
  // ----------------------------------------------------------------
  // Clocks, checks and scenarios
  // ----------------------------------------------------------------
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Held long enough to pass the synchroniser and the shortened debounce.
  task automatic press(ref logic b);
    b = 0;
    repeat (12) @(negedge clk);
    b = 1;
    repeat (12) @(negedge clk);
  endtask
  task automatic t_pcs(bit rx);
    int n = 0;
    repeat (6) @(negedge clk);
    chk("pcs reset before lock", 1'b0, rx ? rx_rst : tx_rst);
    if (rx) rxl = 1;
    else txl = 1;
    repeat (20) begin
      @(negedge clk);
      n += (rx ? rx_rst : tx_rst) === 1'b1;
    end
    chk("pcs reset pulse", 1'b1, n == 4);
  endtask
  task automatic t_status;
    int na = 0, nb = 0, nc = 0;
    repeat (30) begin
      @(negedge clk);
      na += hb_a === 1'b1;
      nb += hb_b === 1'b1;
      nc += hb_c === 1'b1;
    end
    chk("heartbeat a", 1'b1, na > 0);
    chk("heartbeat b", 1'b1, nb > 0);
    chk("heartbeat c", 1'b1, nc > 0);
    chk("port a tx lamp", 1'b1, a_tx);
    chk("port a rx lamp", 1'b1, a_rx);
    chk("card lamp", 1'b1, cp);
    chk("lock lamp", 1'b1, lock);
    pcl = 0;
    repeat (6) @(negedge clk);
    chk("lock lamp lost", 1'b0, lock);
    pcl = 1;
  endtask
  task automatic t_run;
    press(seq_b);
    press(seq_b);
    repeat (100) @(negedge clk);
    chk("sync before start", 1'b0, sync);
    press(seq_b);
    for (int i = 0; i < 3000 && sync !== 1'b1; i++) @(negedge clk);
    chk("sync lamp", 1'b1, sync);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    chk("done lamp", 1'b1, done);
    chk("error lamp clean", 1'b0, err);
  endtask
  task automatic t_err;
    press(seq_b);
    for (int i = 0; i < 100 && err !== 1'b1; i++) @(negedge clk);
    chk("error lamp", 1'b1, err);
    press(view_b);
    repeat (100) @(negedge clk);
    chk("error held in view", 1'b1, err);
    // Every group saw the injected error, so each view keeps the lamp lit.
    repeat (3) begin
      press(view_b);
      chk("error in next view", 1'b1, err);
    end
  endtask
  task automatic t_misc;
    repeat (10) @(negedge clk);
    @(negedge link_clk);
    chk("forwarded clock 0 deg", xt[1], fc);
    @(negedge clk);
    phase = 1;
    repeat (10) @(negedge clk);
    @(negedge link_clk);
    chk("forwarded clock 180 deg", ~xt[1], fc);
    @(negedge clk);
    fit = 0;
    repeat (6) @(negedge clk);
    chk("card lamp absent", 1'b0, cp);
    pa_en = 0;
    txl = 0;
    repeat (6) @(negedge clk);
    chk("lock lamp port a off", 1'b1, lock);
  endtask
  initial begin
    #1ms;
    failures++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    t_pcs(0);
    t_pcs(1);
    t_status();
    t_run();
    t_err();
    press(sys_b);
    chk("error cleared", 1'b0, err);
    chk("sync cleared", 1'b0, sync);
    t_misc();
    end_sim();
  end
endmodule
